//--- pam_pkg.sv
// package: constants and carrier types for the port alternate-function and led drive block
package pam_pkg;
  // port widths
  localparam int PORT_A_WIDTH = 8;
  localparam int PORT_C_WIDTH = 8;
  // port a bit positions
  localparam int POS_DEBUG_PIN = 0;
  localparam int POS_TIMER0_OUTPUT = 1;
  localparam int POS_RESET_PIN = 2;
  localparam int POS_UART_CTS = 3;
  localparam int POS_UART_RX = 4;
  localparam int POS_UART_TX = 5;
  localparam int POS_TIMER1_SHARED = 6;
  localparam int POS_TIMER1_OUTPUT = 7;
  localparam int POS_TIMER0_SHARED = 0;
  localparam int POS_UART_DE = 2;
  // led sink levels in mA, indexed by {high bit, low bit}
  localparam int LED_LEVEL0_MA = 3;
  localparam int LED_LEVEL1_MA = 7;
  localparam int LED_LEVEL2_MA = 13;
  localparam int LED_LEVEL3_MA = 20;
  // led level codes
  localparam logic [1:0] LED_CODE_3MA = 2'h0;
  localparam logic [1:0] LED_CODE_7MA = 2'h1;
  localparam logic [1:0] LED_CODE_13MA = 2'h2;
  localparam logic [1:0] LED_CODE_20MA = 2'h3;
  // timer mode code for dual pwm output
  localparam logic [3:0] TIMER_MODE_DUAL_PWM = 4'h8;
  // reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // debug unlock pattern length in samples
  localparam int UNLOCK_LEN = 8;
  localparam logic [7:0] UNLOCK_PATTERN = 8'hA5;

  // pin function of the shared reset / port a bit 2 pin
  typedef enum logic [0:0] {
    RST_FUNC_RESET = 1'b0,
    RST_FUNC_GPIO = 1'b1
  } pam_rst_func_type;

  // per-port configuration bundle
  typedef struct packed {
    logic [7:0] outData;
    logic [7:0] outEnable;
    logic [7:0] altFunctionEnable;
    logic [7:0] altSelectLow;
    logic [7:0] altSelectHigh;
  } pam_port_cfg_type;

  // led configuration bundle
  typedef struct packed {
    logic [7:0] ledDriverEnable;
    logic [7:0] ledLevelHighBits;
    logic [7:0] ledLevelLowBits;
  } pam_led_cfg_type;

  // peripheral outputs that may reach port a
  typedef struct packed {
    logic timer0Output;
    logic timer0OutComplement;
    logic timer1Output;
    logic timer1OutComplement;
    logic uartDriverEnable;
    logic uartTransmitLine;
    logic [3:0] timer0Mode;
    logic [3:0] timer1Mode;
  } pam_periph_out_type;
endpackage

//--- pam_port_mux.sv
// file: port a / port c pin function selection with led drive and shared reset and debug pins
`timescale 1ns/1ns
module pam_port_mux
  import pam_pkg::*;
#(
  parameter int PIN_COUNT = 20,
  parameter int LED_WIDTH = PORT_C_WIDTH
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // configuration from the port sub-registers
  input wire pam_port_cfg_type portACfg,
  input wire pam_port_cfg_type portCCfg,
  input wire pam_led_cfg_type ledCfg,
  input wire logic releaseResetFunction,
  // peripherals
  input wire pam_periph_out_type periphOut,
  // port a pins
  input wire logic [7:0] portAIn,
  output logic [7:0] portAOut,
  output logic [7:0] portAOe,
  // port c pins
  input wire logic [7:0] portCIn,
  output logic [7:0] portCOut,
  output logic [7:0] portCOe,
  output logic [7:0] ledSinkOn,
  output logic [15:0] ledLevelCode,
  // synchronised inputs to peripherals
  output logic [7:0] portAInSync,
  output logic [7:0] portCInSync,
  output logic timer0Input,
  output logic timer1Input,
  output logic uartClearToSend,
  output logic uartReceiveLine,
  // reset and debug pin functions
  output logic pinResetRequest,
  output logic debugUnlocked,
  output logic debugPinIn,
  output logic resetPinIsGpio
);

  // elaboration checks: only 8-bit ports and known packages are served
  if (LED_WIDTH != PORT_C_WIDTH) begin
    $error("pam_port_mux: LED_WIDTH must equal port c width");
  end
  if (PIN_COUNT != 8 && PIN_COUNT != 20 && PIN_COUNT != 28) begin
    $error("pam_port_mux: unsupported PIN_COUNT");
  end

  // package flag: reset and debug sharing exist only on the smallest package
  localparam logic SMALL_PKG = (PIN_COUNT == 8);

  // whole state of the module
  typedef struct packed {
    logic [7:0] syncA1;
    logic [7:0] syncA2;
    logic [7:0] syncC1;
    logic [7:0] syncC2;
    pam_rst_func_type rstFunc;
    logic debugUnlocked;
    logic [7:0] unlockShift;
    logic [7:0] aOut;
    logic [7:0] aOe;
    logic [7:0] cOut;
    logic [7:0] cOe;
    logic [7:0] ledOn;
    logic [15:0] ledCode;
    logic t0In;
    logic t1In;
    logic cts;
    logic rxd;
    logic rstReq;
  } pam_state_type;

  pam_state_type state_reg;
  pam_state_type state_next;
  logic t0IsOutput; // timer0 shared pin carries complement output
  logic t1IsOutput; // timer1 shared pin carries complement output

  // next-state logic
  always_comb begin
    state_next = state_reg;
    // second stage only reads first stage
    state_next.syncA1 = portAIn;
    state_next.syncA2 = state_reg.syncA1;
    state_next.syncC1 = portCIn;
    state_next.syncC2 = state_reg.syncC1;

    t0IsOutput = (periphOut.timer0Mode == TIMER_MODE_DUAL_PWM);
    t1IsOutput = (periphOut.timer1Mode == TIMER_MODE_DUAL_PWM);

    // defaults: plain gpio from the output and direction registers
    state_next.aOut = portACfg.outData;
    state_next.aOe = portACfg.outEnable;

    // enable alone connects; select registers ignored on port a
    if (portACfg.altFunctionEnable[POS_TIMER0_SHARED]) begin
      state_next.aOut[POS_TIMER0_SHARED] = periphOut.timer0OutComplement;
      state_next.aOe[POS_TIMER0_SHARED] = t0IsOutput;
    end
    if (portACfg.altFunctionEnable[POS_TIMER0_OUTPUT]) begin
      state_next.aOut[POS_TIMER0_OUTPUT] = periphOut.timer0Output;
      state_next.aOe[POS_TIMER0_OUTPUT] = 1'b1;
    end
    if (portACfg.altFunctionEnable[POS_UART_DE]) begin
      state_next.aOut[POS_UART_DE] = periphOut.uartDriverEnable;
      state_next.aOe[POS_UART_DE] = 1'b1;
    end
    if (portACfg.altFunctionEnable[POS_UART_CTS]) begin
      state_next.aOe[POS_UART_CTS] = 1'b0;
    end
    if (portACfg.altFunctionEnable[POS_UART_RX]) begin
      state_next.aOe[POS_UART_RX] = 1'b0;
    end
    if (portACfg.altFunctionEnable[POS_UART_TX]) begin
      state_next.aOut[POS_UART_TX] = periphOut.uartTransmitLine;
      state_next.aOe[POS_UART_TX] = 1'b1;
    end
    if (portACfg.altFunctionEnable[POS_TIMER1_SHARED]) begin
      state_next.aOut[POS_TIMER1_SHARED] = periphOut.timer1OutComplement;
      state_next.aOe[POS_TIMER1_SHARED] = t1IsOutput;
    end
    if (portACfg.altFunctionEnable[POS_TIMER1_OUTPUT]) begin
      state_next.aOut[POS_TIMER1_OUTPUT] = periphOut.timer1Output;
      state_next.aOe[POS_TIMER1_OUTPUT] = 1'b1;
    end

    // timer inputs are gated off while the pin carries the complement
    state_next.t0In = portACfg.altFunctionEnable[POS_TIMER0_SHARED] & ~t0IsOutput &
                      state_reg.syncA2[POS_TIMER0_SHARED];
    state_next.t1In = portACfg.altFunctionEnable[POS_TIMER1_SHARED] & ~t1IsOutput &
                      state_reg.syncA2[POS_TIMER1_SHARED];
    // idle levels when alternate input not enabled: cts asserted low, rx idle high
    state_next.cts = portACfg.altFunctionEnable[POS_UART_CTS] ? state_reg.syncA2[POS_UART_CTS] : 1'b0;
    state_next.rxd = portACfg.altFunctionEnable[POS_UART_RX] ? state_reg.syncA2[POS_UART_RX] : 1'b1;

    // shared reset pin, full gpio once released
    if (SMALL_PKG) begin
      if (state_reg.rstFunc == RST_FUNC_RESET) begin
        // open-drain reset input: never driven here
        state_next.aOe[POS_RESET_PIN] = 1'b0;
        state_next.aOut[POS_RESET_PIN] = 1'b0;
        state_next.rstReq = ~state_reg.syncA2[POS_RESET_PIN];
        if (releaseResetFunction && state_reg.syncA2[POS_RESET_PIN]) begin
          state_next.rstFunc = RST_FUNC_GPIO;
        end
      end else begin
        state_next.rstReq = 1'b0;
      end
    end else begin
      state_next.rstReq = 1'b0;
    end

    // debug pin defaults to gpio input
    if (SMALL_PKG) begin
      if (state_reg.debugUnlocked) begin
        // debug owns the pin; port logic leaves it undriven
        state_next.aOe[POS_DEBUG_PIN] = 1'b0;
        state_next.aOut[POS_DEBUG_PIN] = 1'b0;
        state_next.t0In = 1'b0;
      end else if (state_reg.rstFunc == RST_FUNC_RESET) begin
        // watch for unlock pattern while the shared pin keeps its reset function
        state_next.unlockShift = {state_reg.unlockShift[6:0], state_reg.syncA2[POS_DEBUG_PIN]};
        if (state_reg.unlockShift == UNLOCK_PATTERN) begin
          state_next.debugUnlocked = 1'b1;
        end
      end
    end

    // port c: plain gpio unless led drive is fully armed
    state_next.cOut = portCCfg.outData;
    state_next.cOe = portCCfg.outEnable;
    for (int i = 0; i < PORT_C_WIDTH; i++) begin
      // select low chooses led, enable bit turns on
      state_next.ledOn[i] = portCCfg.altSelectLow[i] & portCCfg.altFunctionEnable[i] &
                            ledCfg.ledDriverEnable[i];
      // level code from high and low bits
      // code 0..3 maps to 3, 7, 13, 20 mA
      state_next.ledCode[2*i +: 2] = {ledCfg.ledLevelHighBits[i], ledCfg.ledLevelLowBits[i]};
      if (state_next.ledOn[i]) begin
        // sinking current: pull the cathode low
        state_next.cOut[i] = 1'b0;
        state_next.cOe[i] = 1'b1;
      end
    end
  end

  // state register; reset puts the shared pin back to its reset function
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
      state_reg.rstFunc <= RST_FUNC_RESET;
      state_reg.rxd <= 1'b1;
      // reset pin synchroniser starts at the pull-up level, so no false reset request follows reset
      state_reg.syncA1[POS_RESET_PIN] <= 1'b1;
      state_reg.syncA2[POS_RESET_PIN] <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from the state register
  assign portAOut = state_reg.aOut;
  assign portAOe = state_reg.aOe;
  assign portCOut = state_reg.cOut;
  assign portCOe = state_reg.cOe;
  assign ledSinkOn = state_reg.ledOn;
  assign ledLevelCode = state_reg.ledCode;
  assign portAInSync = state_reg.syncA2;
  assign portCInSync = state_reg.syncC2;
  assign timer0Input = state_reg.t0In;
  assign timer1Input = state_reg.t1In;
  assign uartClearToSend = state_reg.cts;
  assign uartReceiveLine = state_reg.rxd;
  assign pinResetRequest = state_reg.rstReq;
  assign debugUnlocked = state_reg.debugUnlocked;
  assign debugPinIn = state_reg.syncA2[POS_DEBUG_PIN];
  assign resetPinIsGpio = (state_reg.rstFunc == RST_FUNC_GPIO);
endmodule

//--- pam_port_mux_checker.sv
// concurrent checks on the port alternate-function and led drive block
`timescale 1ns/1ns
module pam_port_mux_checker
  import pam_pkg::*;
#(
  parameter int PIN_COUNT = 20
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // configuration and peripherals
  input wire pam_port_cfg_type portACfg,
  input wire pam_port_cfg_type portCCfg,
  input wire pam_led_cfg_type ledCfg,
  input wire pam_periph_out_type periphOut,
  // pins and pin functions
  input wire logic [7:0] portAIn,
  input wire logic [7:0] portAOut,
  input wire logic [7:0] portAOe,
  input wire logic [7:0] portCOut,
  input wire logic [7:0] portCOe,
  input wire logic [7:0] ledSinkOn,
  input wire logic [15:0] ledLevelCode,
  input wire logic pinResetRequest,
  input wire logic debugUnlocked,
  input wire logic resetPinIsGpio
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // level code interleaved as {high, low} per pin
  function automatic logic [15:0] weave(input logic [7:0] h, input logic [7:0] l);
    for (int i = 0; i < 8; i++) begin
      weave[2*i+1] = h[i];
      weave[2*i] = l[i];
    end
  endfunction
  led_sink_a: assert property (!$past(rst) |-> ledSinkOn ==
    $past(portCCfg.altFunctionEnable & portCCfg.altSelectLow & ledCfg.ledDriverEnable)) else $error("led sink wrong");
  led_level_a: assert property (!$past(rst) |-> ledLevelCode ==
    weave($past(ledCfg.ledLevelHighBits), $past(ledCfg.ledLevelLowBits))) else $error("led level wrong");
  led_drive_a: assert property ((portCOe & ledSinkOn) == ledSinkOn &&
    (portCOut & ledSinkOn) == 8'h00) else $error("led pin not sinking");
  port_a_map_a: assert property (!$past(rst) |-> ((portAOut ^ {$past(periphOut.timer1Output), 1'b0,
    $past(periphOut.uartTransmitLine), 3'h0, $past(periphOut.timer0Output), 1'b0}) & $past(portACfg.altFunctionEnable)
    & 8'hA2) == 8'h00) else $error("port a map wrong");
  dual_pwm_a: assert property (!$past(rst) && $past(portACfg.altFunctionEnable[6]) &&
    $past(periphOut.timer1Mode) == TIMER_MODE_DUAL_PWM |-> portAOe[6] && portAOut[6] == $past(periphOut.timer1OutComplement))
    else $error("complement output wrong");
  plain_c_a: assert property (!$past(rst) |-> ((portCOe ^ $past(portCCfg.outEnable)) &
    ~$past(portCCfg.altFunctionEnable)) == 8'h00) else $error("plain port c wrong");
  reset_hold_a: assert property ((PIN_COUNT == 8 && !resetPinIsGpio && !portAIn[2]) [*4] |->
    pinResetRequest) else $error("reset request missing");
  gpio_sticky_a: assert property (resetPinIsGpio |=> resetPinIsGpio) else $error("gpio mode dropped");
  debug_sticky_a: assert property (debugUnlocked |=> debugUnlocked) else $error("debug unlock dropped");
endmodule
bind pam_port_mux pam_port_mux_checker #(.PIN_COUNT(PIN_COUNT)) pam_port_mux_checker_i (.clk_sys, .rst, .portACfg,
  .portCCfg, .ledCfg, .periphOut, .portAIn, .portAOut, .portAOe, .portCOut, .portCOe, .ledSinkOn, .ledLevelCode,
  .pinResetRequest, .debugUnlocked, .resetPinIsGpio);

//--- pam_board_model.sv
// board model: pull-up on every pin plus a bench-commanded low driver
`timescale 1ns/1ns
module pam_board_model (
  // device pin drivers
  input wire logic [7:0] devOut,
  input wire logic [7:0] devOe,
  // external low drive requests
  input wire logic [7:0] extLow,
  // resolved pin levels
  output logic [7:0] pinLevel
);
  // idle pins float high; a low from either side wins, as on an open-drain line
  always_comb begin
    pinLevel = ~extLow & (~devOe | devOut);
  end
endmodule

//--- pam_port_mux_tb.sv
// testbench for the port alternate-function and led drive block
`timescale 1ns/1ns
module pam_port_mux_tb;
  import pam_pkg::*;
  // bench-driven inputs
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic releaseResetFunction = 1'b0;
  pam_port_cfg_type portACfg = '0;
  pam_port_cfg_type portCCfg = '0;
  pam_led_cfg_type ledCfg = '0;
  pam_periph_out_type periphOut = '0;
  logic [7:0] extLowA = 8'h00;
  logic [7:0] extLowC = 8'h00;
  // pins and design outputs
  logic [7:0] portAIn, portCIn, portAOut, portAOe, portCOut, portCOe, ledSinkOn, portAInSync, portCInSync;
  logic [15:0] ledLevelCode;
  logic timer0Input, timer1Input, uartClearToSend, uartReceiveLine, pinResetRequest, debugUnlocked, debugPinIn;
  logic resetPinIsGpio;
  int fails = 0;
  int checks = 0;
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  // small package build, so the shared reset and debug pins exist
  pam_port_mux #(.PIN_COUNT(8)) pam_port_mux_i (.clk_sys(clk_sys), .rst(rst), .portACfg(portACfg),
    .portCCfg(portCCfg), .ledCfg(ledCfg), .releaseResetFunction(releaseResetFunction), .periphOut(periphOut),
    .portAIn(portAIn), .portAOut(portAOut), .portAOe(portAOe), .portCIn(portCIn), .portCOut(portCOut),
    .portCOe(portCOe), .ledSinkOn(ledSinkOn), .ledLevelCode(ledLevelCode), .portAInSync(portAInSync),
    .portCInSync(portCInSync), .timer0Input(timer0Input), .timer1Input(timer1Input),
    .uartClearToSend(uartClearToSend), .uartReceiveLine(uartReceiveLine), .pinResetRequest(pinResetRequest),
    .debugUnlocked(debugUnlocked), .debugPinIn(debugPinIn), .resetPinIsGpio(resetPinIsGpio));
  pam_board_model pam_board_model_i (.devOut(portAOut), .devOe(portAOe), .extLow(extLowA), .pinLevel(portAIn));
  pam_board_model pam_board_model_c_i (.devOut(portCOut), .devOe(portCOe), .extLow(extLowC), .pinLevel(portCIn));
  task automatic step(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // bounded wait, as the unlock and release latencies are the design's choice
  task automatic waitHigh(input bit forDebug);
    for (int k = 0; k < 12 && (forDebug ? debugUnlocked : resetPinIsGpio) !== 1'b1; k++) begin
      step(1);
    end
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #4000;
    fails++;
    wrap_up();
  end
  initial begin
    step(3);
    chk({ledSinkOn, portAOe}, 16'h0000);
    rst = 1'b0;
    step(4);
    chk({13'h0000, resetPinIsGpio, pinResetRequest, portAOe[0]}, 16'h0000);
    // selects before enable; pins 0-3 take codes 0-3
    portCCfg.altSelectLow = 8'h3F;
    portCCfg.outData = 8'h55;
    portCCfg.outEnable = 8'hC0;
    ledCfg = {8'h0F, 8'h0C, 8'h0A};
    step(1);
    portCCfg.altFunctionEnable = 8'h3F;
    step(3);
    chk(ledLevelCode, 16'h00E4);
    chk({ledSinkOn, portCOe}, 16'h0FCF);
    chk({portCOut & 8'hCF, portCInSync}, 16'h4070);
    ledCfg = {8'h00, 8'hFF, 8'h0A};
    step(1);
    chk({ledSinkOn, ledLevelCode[7:0]}, 16'h00EE);
    // port a selects written first, then ignored
    portACfg.altSelectLow = 8'hFF;
    portACfg.altSelectHigh = 8'hFF;
    periphOut = {6'h2F, 4'h0, TIMER_MODE_DUAL_PWM};
    step(1);
    portACfg.altFunctionEnable = 8'hFB;
    // receive line pulled low, clear-to-send left high: both differ from their idle values
    extLowA = 8'h10;
    step(4);
    chk({portAOut & 8'hE2, portAOe & 8'hE3}, 16'hE2E2);
    chk({13'h0000, timer0Input, uartClearToSend, uartReceiveLine}, 16'h0006);
    periphOut.timer0Mode = TIMER_MODE_DUAL_PWM;
    periphOut.timer1Mode = 4'h0;
    extLowA = 8'h40;
    step(4);
    chk({12'h000, portAOe[0], portAOut[0], portAOe[6], timer1Input}, 16'h0008);
    extLowA = 8'h04;
    step(4);
    chk({15'h0000, pinResetRequest}, 16'h0001);
    extLowA = 8'h00;
    releaseResetFunction = 1'b1;
    waitHigh(1'b0);
    portACfg.outEnable = 8'h04;
    step(1);
    chk({13'h0000, resetPinIsGpio, portAOe[2], portAOut[2]}, 16'h0006);
    portACfg.outEnable = 8'h00;
    extLowA = 8'h04;
    step(4);
    chk({14'h0000, portAInSync[2], pinResetRequest}, 16'h0000);
    releaseResetFunction = 1'b0;
    // pin 0 left undriven so the unlock pattern reaches it; timer0 input kept on to show the debug takeover
    portACfg = '0;
    portACfg.altFunctionEnable = 8'h01;
    periphOut = '0;
    rst = 1'b1;
    step(1);
    rst = 1'b0;
    step(4);
    chk({14'h0000, resetPinIsGpio, pinResetRequest}, 16'h0001);
    extLowA = 8'h00;
    for (int k = 7; k >= 0; k--) begin
      extLowA[0] = ~UNLOCK_PATTERN[k];
      step(1);
    end
    extLowA[0] = 1'b0;
    waitHigh(1'b1);
    step(1);
    chk({12'h000, debugUnlocked, portAOe[0], timer0Input, debugPinIn}, 16'h0009);
    wrap_up();
  end
endmodule
